// [hw/adc_fifo_defs.svh]
// Offsets, field positions, sizes and reset values of the result buffer
`ifndef ADC_FIFO_DEFS_SVH
`define ADC_FIFO_DEFS_SVH

`define OFS_IRQ_CTRL 5'h06
`define OFS_IRQ_CLEAR 5'h14
`define OFS_SAMPLE_LOW 5'h17
`define OFS_SAMPLE_HIGH 5'h18
`define OFS_FLAGS 5'h19
`define FIFO_DEPTH 11'h400
`define FIFO_HALF 11'h200
`define BIT_FULL 2
`define BIT_HALF 1
`define BIT_EMPTY 0
`define BIT_IRQ_ALLOW 0
`define IRQ_ALLOW_RESET 1'h0

`endif

// [hw/adc_fifo_pkg.sv]
// Types shared by the result buffer
package adc_fifo_pkg;
  typedef logic [4:0] io_addr_t;
  typedef logic [10:0] level_t;
  typedef logic [9:0] ptr_t;
  typedef logic [15:0] entry_t;
endpackage : adc_fifo_pkg

// [hw/adc_result_fifo.sv]
// Conversion result buffer with byte-wide I/O register access
`timescale 1ns/100ps
`include "adc_fifo_defs.svh"

module adc_result_fifo (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Byte-wide I/O register port
  input wire logic [4:0] io_addr_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // Conversion sequencer write side
  input wire logic res_valid_in,
  input wire logic [11:0] res_data_in,
  input wire logic [3:0] res_chan_in,
  output logic res_ready_out,
  // Interrupt request toward host routing
  output logic buffer_irq_out
);

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  adc_fifo_pkg::entry_t mem [0:1023];
  adc_fifo_pkg::ptr_t wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  adc_fifo_pkg::level_t level_reg, level_next;
  logic [7:0] rdata_reg, rdata_next;
  logic buffer_irq_allow_reg, buffer_irq_allow_next;
  logic irq_pend_reg, irq_pend_next;
  logic empty_indicator, half_level_indicator, full_indicator;
  logic push, pop, flush;
  adc_fifo_pkg::entry_t head;

  // Register address match, used by several decodes
  function automatic logic hit(input adc_fifo_pkg::io_addr_t a,
                               input adc_fifo_pkg::io_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  // Flags straight from the level count
  assign empty_indicator = (level_reg == 11'h000);
  assign half_level_indicator = (level_reg >= `FIFO_HALF);
  assign full_indicator = (level_reg == `FIFO_DEPTH);
  assign head = mem[rd_ptr_reg];

  // Handshakes; flush takes priority so a flushed cycle stores nothing
  assign flush = io_wr_in && hit(io_addr_in, `OFS_FLAGS);
  assign res_ready_out = !full_indicator && !flush;
  assign push = res_valid_in && res_ready_out;
  assign pop = io_rd_in && hit(io_addr_in, `OFS_SAMPLE_HIGH) && !empty_indicator;

  // Next-state for pointers, level, control and read data
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    level_next = level_reg;
    buffer_irq_allow_next = buffer_irq_allow_reg;
    irq_pend_next = irq_pend_reg;
    rdata_next = rdata_reg;
    if (flush) begin
      wr_ptr_next = 10'h000;
      rd_ptr_next = 10'h000;
      level_next = 11'h000;
    end else begin
      if (push) begin
        wr_ptr_next = wr_ptr_reg + 10'h001;
      end
      if (pop) begin
        rd_ptr_next = rd_ptr_reg + 10'h001;
      end
      level_next = level_reg + {10'h000, push} - {10'h000, pop};
    end
    if (io_wr_in && hit(io_addr_in, `OFS_IRQ_CTRL)) begin
      buffer_irq_allow_next = io_wdata_in[`BIT_IRQ_ALLOW];
    end
    // Request rises when the store crosses half; set wins over clear
    if (push && !pop && level_reg == `FIFO_HALF - 11'h001) begin
      irq_pend_next = 1'b1;
    end else if (io_wr_in && hit(io_addr_in, `OFS_IRQ_CLEAR)) begin
      irq_pend_next = 1'b0;
    end
    if (io_rd_in) begin
      case (io_addr_in)
        `OFS_SAMPLE_LOW: rdata_next = {head[3:0], head[15:12]};
        `OFS_SAMPLE_HIGH: rdata_next = head[11:4];
        `OFS_FLAGS: rdata_next = {5'h00, full_indicator, half_level_indicator,
                                  empty_indicator};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Entry layout: [15:12] channel, [11:0] result
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= {res_chan_in, res_data_in};
    end
  end

  // State registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= 10'h000;
      rd_ptr_reg <= 10'h000;
      level_reg <= 11'h000;
      rdata_reg <= 8'h00;
      buffer_irq_allow_reg <= `IRQ_ALLOW_RESET;
      irq_pend_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      level_reg <= level_next;
      rdata_reg <= rdata_next;
      buffer_irq_allow_reg <= buffer_irq_allow_next;
      irq_pend_reg <= irq_pend_next;
    end
  end

  assign io_rdata_out = rdata_reg;
  assign buffer_irq_out = irq_pend_reg && buffer_irq_allow_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_empty_flag;
    @(posedge mclk_in) disable iff (rst_in)
      io_rd_in && hit(io_addr_in, `OFS_FLAGS) |=>
        io_rdata_out[`BIT_EMPTY] == ($past(level_reg) == 11'h000);
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");

  property p_half;
    @(posedge mclk_in) disable iff (rst_in)
      half_level_indicator == (level_reg > 11'h1ff);
  endproperty
  a_half: assert property (p_half) else $error("half flag wrong");

  // Half flag may only rise on the single entry that reaches half capacity
  property p_half_rise;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(half_level_indicator) |-> level_reg == 11'h200 && $past(level_reg) == 11'h1ff;
  endproperty
  a_half_rise: assert property (p_half_rise) else $error("half rose off boundary");

  property p_full;
    @(posedge mclk_in) disable iff (rst_in)
      full_indicator |-> !res_ready_out && level_reg == 11'h400;
  endproperty
  a_full: assert property (p_full) else $error("full flag wrong");

  // A full store must refuse the offered result, so the write pointer holds
  property p_full_refuse;
    @(posedge mclk_in) disable iff (rst_in)
      full_indicator && !flush |=> $stable(wr_ptr_reg) && level_reg <= 11'h400;
  endproperty
  a_full_refuse: assert property (p_full_refuse) else $error("push taken while full");

  property p_flush;
    @(posedge mclk_in) disable iff (rst_in)
      flush |=> level_reg == 11'h000 && rd_ptr_reg == wr_ptr_reg;
  endproperty
  a_flush: assert property (p_flush) else $error("flush did not empty");

  // Count and pointers are kept apart; a slip between them would lose entries
  property p_level_ptrs;
    @(posedge mclk_in) disable iff (rst_in)
      level_reg[9:0] == wr_ptr_reg - rd_ptr_reg;
  endproperty
  a_level_ptrs: assert property (p_level_ptrs) else $error("level vs pointers");

  property p_pop_advance;
    @(posedge mclk_in) disable iff (rst_in)
      pop && !flush |=> rd_ptr_reg == $past(rd_ptr_reg) + 10'h001;
  endproperty
  a_pop_advance: assert property (p_pop_advance) else $error("pop did not advance");

  property p_empty_read;
    @(posedge mclk_in) disable iff (rst_in)
      empty_indicator && !push && !flush |=> $stable(rd_ptr_reg) && level_reg == 11'h000;
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty store changed");

  property p_low_layout;
    @(posedge mclk_in) disable iff (rst_in)
      io_rd_in && hit(io_addr_in, `OFS_SAMPLE_LOW) |=>
        io_rdata_out == {$past(head[3:0]), $past(head[15:12])};
  endproperty
  a_low_layout: assert property (p_low_layout) else $error("low register layout");

  property p_irq_clear;
    @(posedge mclk_in) disable iff (rst_in)
      io_wr_in && hit(io_addr_in, `OFS_IRQ_CLEAR) && !(push && level_reg == 11'h1ff)
        |=> !buffer_irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not withdrawn");

  property p_irq_mask;
    @(posedge mclk_in) disable iff (rst_in)
      !buffer_irq_allow_reg |-> !buffer_irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");

  // Main scenarios the bench is expected to reach
  c_fill: cover property (@(posedge mclk_in) full_indicator);
  c_half: cover property (@(posedge mclk_in) $rose(half_level_indicator));
  c_flush_busy: cover property (@(posedge mclk_in) flush && !empty_indicator);
  c_irq: cover property (@(posedge mclk_in) $rose(buffer_irq_out));

endmodule : adc_result_fifo

// [verif/seq_model.sv]
// Behavioural conversion sequencer feeding results into the buffer
`timescale 1ns/100ps
module seq_model (
  // Clock and handshake
  input wire logic mclk_in,
  input wire logic ready_in,
  // Result toward the buffer
  output logic valid_out,
  output logic [11:0] data_out,
  output logic [3:0] chan_out
);
  int sent = 0;
  // Idle at time zero
  initial begin
    valid_out = 1'b0;
    data_out = 12'h000;
    chan_out = 4'h0;
  end
  // Offers n results; a gap makes it a slow source, released lines show inverse
  task automatic push(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk_in);
      valid_out = 1'b1;
      data_out = 12'(sent * 7 + 1);
      chan_out = 4'(sent);
      do @(posedge mclk_in); while (!ready_in);
      sent++;
      if (gap > 0 || i == n - 1) begin
        @(negedge mclk_in);
        valid_out = 1'b0;
        data_out = ~data_out;
        chan_out = ~chan_out;
        repeat (gap) @(negedge mclk_in);
      end
    end
  endtask : push
endmodule : seq_model

// [verif/tb.sv]
// Self-checking bench for the conversion result buffer
`timescale 1ns/100ps
module tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] io_addr_in = 5'h00;
  logic io_rd_in = 1'b0;
  logic io_wr_in = 1'b0;
  logic [7:0] io_wdata_in = 8'h00;
  logic [7:0] io_rdata_out;
  logic [7:0] rd;
  logic res_valid_in, res_ready_out, buffer_irq_out;
  logic [11:0] res_data_in;
  logic [3:0] res_chan_in;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int idx = 0;
  always #5 mclk_in = ~mclk_in;
  adc_result_fifo adc_result_fifo_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
    .res_valid_in(res_valid_in), .res_data_in(res_data_in), .res_chan_in(res_chan_in),
    .res_ready_out(res_ready_out), .buffer_irq_out(buffer_irq_out));
  seq_model seq_model_i (.mclk_in(mclk_in), .ready_in(res_ready_out),
    .valid_out(res_valid_in), .data_out(res_data_in), .chan_out(res_chan_in));
  // ----------------------------------------
  // Bus tasks and reporting
  // ----------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // Hang guard, well above the roughly 5200 cycles the run needs
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One-cycle strobe; data is settled at the following falling edge
  task automatic io_read(input logic [4:0] a);
    @(negedge mclk_in);
    io_addr_in = a;
    io_rd_in = 1'b1;
    @(negedge mclk_in);
    io_rd_in = 1'b0;
    rd = io_rdata_out;
  endtask : io_read
  task automatic io_write(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    @(negedge mclk_in);
    io_wr_in = 1'b0;
  endtask : io_write
  task automatic flags(input logic [7:0] exp);
    io_read(5'h19);
    check(rd, exp);
  endtask : flags
  // Low byte first, since the high byte read pops the entry
  task automatic pop_check();
    logic [11:0] d;
    d = 12'(idx * 7 + 1);
    io_read(5'h17);
    check(rd, {d[3:0], 4'(idx)});
    io_read(5'h18);
    check(rd, d[11:4]);
    idx++;
  endtask : pop_check
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_small();
    check(io_rdata_out, 8'h00);
    flags(8'h01);
    seq_model_i.push(3, 1);
    flags(8'h00);
    repeat (3) pop_check();
    io_read(5'h18);
    flags(8'h01);
    io_read(5'h1f);
    check(rd, 8'h00);
  endtask : t_small
  task automatic t_fill();
    seq_model_i.push(511, 0);
    flags(8'h00);
    seq_model_i.push(1, 2);
    flags(8'h02);
    check({7'h00, buffer_irq_out}, 8'h00);
    io_write(5'h06, 8'h01);
    repeat (2) @(negedge mclk_in);
    check({7'h00, buffer_irq_out}, 8'h01);
    io_write(5'h14, 8'h00);
    repeat (2) @(negedge mclk_in);
    check({7'h00, buffer_irq_out}, 8'h00);
    seq_model_i.push(512, 0);
    flags(8'h06);
    check({7'h00, res_ready_out}, 8'h00);
  endtask : t_fill
  task automatic t_drain();
    pop_check();
    flags(8'h02);
    repeat (1021) pop_check();
    flags(8'h00);
    io_write(5'h19, 8'ha5);
    flags(8'h01);
  endtask : t_drain
  // Reset in mid-run drops held entries and leaves the store usable
  task automatic t_reset();
    seq_model_i.push(2, 0);
    flags(8'h00);
    @(negedge mclk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    idx = seq_model_i.sent;
    check({6'h00, res_ready_out, buffer_irq_out}, 8'h02);
    flags(8'h01);
    seq_model_i.push(1, 0);
    pop_check();
    flags(8'h01);
  endtask : t_reset
  initial begin
    repeat (3) @(negedge mclk_in);
    rst_in = 1'b0;
    t_small();
    t_fill();
    t_drain();
    t_reset();
    finish_test();
  end
endmodule : tb
